// File: irq_routing_and_measurement_settings_config.v
// routing, timing and measurement register bank with interrupt pin drive and motion processing
//
// Added by the designer: the Avalon-MM register port.
`timescale 1ns/1ps
`include "irq_cfg_map.vh"

module irq_routing_and_measurement_settings_config #(
  parameter WM_W    = `WM_COUNT_W,
  parameter CLK_MHZ = 125
) (
  input  wire            clk,
  input  wire            resetn,
  input  wire [7:0]      avs_address,
  input  wire            avs_read,
  input  wire            avs_write,
  input  wire [31:0]     avs_writedata,
  input  wire [3:0]      avs_byteenable,
  output reg  [31:0]     avs_readdata,
  output reg             avs_waitrequest,
  input  wire            ev_sample_ready,
  input  wire            ev_queue_nonempty,
  input  wire            ev_queue_overflow,
  input  wire [WM_W-1:0] queue_level,
  input  wire [WM_W-1:0] queue_watermark,
  input  wire            still_detected,
  input  wire            motion_detected,
  input  wire            ev_motion_warning,
  input  wire            irq_pin_a_in,
  output reg             irq_pin_a_out,
  output reg             irq_pin_a_oe,
  output reg             irq_pin_b_out,
  output reg             irq_pin_b_oe,
  output reg  [2:0]      output_rate_sel,
  output reg  [2:0]      doze_period_sel,
  output reg             outside_clock_enable,
  output reg             outside_trigger_enable,
  output reg             overrange_disable,
  output reg             low_noise_enable,
  output reg  [2:0]      bandwidth_sel,
  output reg             motion_detect_on,
  output reg             still_detect_on,
  output reg             doze_request,
  output reg             outside_clock_tick
);

  // processing phase states, one-hot
  localparam [1:0] PH_MOTION = 2'b01;
  localparam [1:0] PH_STILL  = 2'b10;

  reg        rst_meta_reg;
  reg        rst_sync_reg;
  reg [7:0]  irq_pin_a_routing;
  reg [7:0]  irq_pin_b_routing;
  reg [7:0]  rate_and_sync_control;
  reg [7:0]  measurement_settings;
  reg [5:0]  motion_enables_reg;
  reg [1:0]  phase_reg;
  reg [1:0]  phase_next;
  reg        awake_reg;
  reg        awake_next;
  reg [7:0]  status_reg;
  reg        ack_pulse_reg;
  reg        outside_clock_enable_d_reg;
  reg        bus_done_reg;
  reg [31:0] rdata_next;
  reg        motion_on_next;
  reg        still_on_next;
  reg        doze_next;

  wire [2:0] motion_axis_enables = motion_enables_reg[`MOTION_EN_MSB:`MOTION_EN_LSB];
  wire [2:0] still_axis_enables  = motion_enables_reg[`STILL_EN_MSB:`STILL_EN_LSB];
  wire [1:0] motion_processing_sel = measurement_settings[`PROC_MSB:`PROC_LSB];
  wire       both_enabled = (&motion_axis_enables) & (&still_axis_enables);
  wire       seq_mode = both_enabled &
                        ((motion_processing_sel == `PROC_LINKED) ||
                         (motion_processing_sel == `PROC_LOOPED));
  wire       looped = seq_mode && (motion_processing_sel == `PROC_LOOPED);
  wire       autosleep = measurement_settings[`AUTOSLEEP_BIT];
  wire       watermark_hit = (queue_level >= queue_watermark);
  wire       motion_ev = motion_detected & motion_on_next;
  wire       still_ev  = still_detected & still_on_next;
  wire       bus_req = (avs_read | avs_write) & ~bus_done_reg;
  wire       wr_fire = avs_write & bus_req;
  wire       rd_fire = avs_read & bus_req;
  wire       wr_lane0 = wr_fire & avs_byteenable[0];
  wire       status_read = rd_fire && (avs_address == `OFS_EVENT_STATUS);
  wire [7:0] raw_events;
  wire       pin_a_any;
  wire       pin_b_any;

  // reset release through two flops
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rst_meta_reg <= 1'b0;
      rst_sync_reg <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_sync_reg <= rst_meta_reg;
    end
  end

  // live event conditions, one bit per function
  assign raw_events[`EV_SAMPLE_READY]    = ev_sample_ready;
  assign raw_events[`EV_QUEUE_NONEMPTY]  = ev_queue_nonempty;
  assign raw_events[`EV_QUEUE_WATERMARK] = watermark_hit;
  assign raw_events[`EV_QUEUE_OVERFLOW]  = ev_queue_overflow;
  assign raw_events[`EV_STILL]           = still_ev;
  assign raw_events[`EV_MOTION]          = motion_ev;
  assign raw_events[`EV_AWAKE]           = awake_reg;
  assign raw_events[`EV_MOTION_WARNING]  = ev_motion_warning;

  // OR of routed latched events per pin; pin b swaps bit 5 for motion warning
  assign pin_a_any = |(irq_pin_a_routing[`ROUTE_MSB:0] & status_reg[`ROUTE_MSB:0]);
  assign pin_b_any = |(irq_pin_b_routing[`ROUTE_MSB:0] &
                       {status_reg[`EV_AWAKE], status_reg[`EV_MOTION_WARNING],
                        status_reg[`EV_STILL:0]});

  // combinational motion processing phase control
  always @* begin
    phase_next     = phase_reg;
    awake_next     = awake_reg;
    motion_on_next = 1'b1;
    still_on_next  = 1'b1;
    doze_next      = 1'b0;
    if (seq_mode) begin
      case (phase_reg)
        PH_MOTION: begin
          still_on_next = 1'b0;
          if (motion_detected) begin
            phase_next = PH_STILL;
            awake_next = 1'b1;
          end
        end
        PH_STILL: begin
          motion_on_next = 1'b0;
          if (still_detected) begin
            phase_next = PH_MOTION;
            awake_next = 1'b0;
            doze_next  = autosleep;
          end
        end
        default: begin
          phase_next = PH_MOTION;
        end
      endcase
    end else begin
      phase_next = PH_MOTION;
      awake_next = 1'b1;
    end
  end

  // write strobes per bank register
  wire       wr_pin_a  = wr_lane0 && (avs_address == `OFS_PIN_A_ROUTING);
  wire       wr_pin_b  = wr_lane0 && (avs_address == `OFS_PIN_B_ROUTING);
  wire       wr_rate   = wr_lane0 && (avs_address == `OFS_RATE_SYNC);
  wire       wr_meas   = wr_lane0 && (avs_address == `OFS_MEASUREMENT);
  wire       wr_motion = wr_lane0 && (avs_address == `OFS_MOTION_ENABLES);
  wire [7:0] status_next;

  // pin a routing register
  always @(posedge clk or negedge rst_sync_reg) begin
    if (!rst_sync_reg) begin
      irq_pin_a_routing <= `REG_RESET_VALUE;
    end else if (wr_pin_a) begin
      irq_pin_a_routing <= avs_writedata[`REG_MSB:0];
    end
  end

  // pin b routing register
  always @(posedge clk or negedge rst_sync_reg) begin
    if (!rst_sync_reg) begin
      irq_pin_b_routing <= `REG_RESET_VALUE;
    end else if (wr_pin_b) begin
      irq_pin_b_routing <= avs_writedata[`REG_MSB:0];
    end
  end

  // rate and sync register
  always @(posedge clk or negedge rst_sync_reg) begin
    if (!rst_sync_reg) begin
      rate_and_sync_control <= `REG_RESET_VALUE;
    end else if (wr_rate) begin
      rate_and_sync_control <= avs_writedata[`REG_MSB:0];
    end
  end

  // measurement register
  always @(posedge clk or negedge rst_sync_reg) begin
    if (!rst_sync_reg) begin
      measurement_settings <= `REG_RESET_VALUE;
    end else if (wr_meas) begin
      measurement_settings <= avs_writedata[`REG_MSB:0];
    end
  end

  // motion and still axis enables
  always @(posedge clk or negedge rst_sync_reg) begin
    if (!rst_sync_reg) begin
      motion_enables_reg <= `ENABLES_RESET;
    end else if (wr_motion) begin
      motion_enables_reg <= avs_writedata[`ENABLES_MSB:0];
    end
  end

  // processing phase and awake flag
  always @(posedge clk or negedge rst_sync_reg) begin
    if (!rst_sync_reg) begin
      phase_reg <= PH_MOTION;
      awake_reg <= 1'b0;
    end else begin
      phase_reg <= phase_next;
      awake_reg <= awake_next;
    end
  end

  // internal ack one cycle after a looped detection
  always @(posedge clk or negedge rst_sync_reg) begin
    if (!rst_sync_reg) begin
      ack_pulse_reg <= 1'b0;
    end else begin
      ack_pulse_reg <= looped & (motion_ev | still_ev);
    end
  end

  // per-event status latch; a new event beats the read clear
  genvar g;
  generate
    for (g = 0; g < `EV_COUNT; g = g + 1) begin : g_status
      // motion and still bits are acked internally in looped mode
      wire acked = ack_pulse_reg & ((g == `EV_MOTION) || (g == `EV_STILL));
      assign status_next[g] = (acked | status_read) ? raw_events[g] :
                              (status_reg[g] | raw_events[g]);
    end
  endgenerate

  // event status register
  always @(posedge clk or negedge rst_sync_reg) begin
    if (!rst_sync_reg) begin
      status_reg <= `STATUS_RESET;
    end else begin
      status_reg <= status_next;
    end
  end

  // read mux for the bank
  always @* begin
    rdata_next = 32'h0000_0000;
    case (avs_address)
      `OFS_PIN_A_ROUTING:  rdata_next[7:0] = irq_pin_a_routing;
      `OFS_PIN_B_ROUTING:  rdata_next[7:0] = irq_pin_b_routing;
      `OFS_RATE_SYNC:      rdata_next[7:0] = rate_and_sync_control;
      `OFS_MEASUREMENT:    rdata_next[7:0] = measurement_settings;
      `OFS_EVENT_STATUS:   rdata_next[7:0] = status_reg | raw_events;
      `OFS_MOTION_ENABLES: rdata_next[`ENABLES_MSB:0] = motion_enables_reg;
      `OFS_CONTROL_STATE:  rdata_next[3:0] = {seq_mode, awake_reg, phase_reg};
      default:             rdata_next = 32'h0000_0000;
    endcase
  end

  // avalon slave: one wait cycle, answer on the second edge
  always @(posedge clk or negedge rst_sync_reg) begin
    if (!rst_sync_reg) begin
      avs_waitrequest <= 1'b1;
      avs_readdata    <= 32'h0000_0000;
      bus_done_reg    <= 1'b0;
    end else begin
      bus_done_reg    <= bus_req;
      avs_waitrequest <= ~bus_req;
      if (rd_fire) begin
        avs_readdata <= rdata_next;
      end
    end
  end

  // pin a drive; released when unrouted or taken as outside clock input
  always @(posedge clk or negedge rst_sync_reg) begin
    if (!rst_sync_reg) begin
      irq_pin_a_out <= 1'b0;
      irq_pin_a_oe  <= 1'b0;
    end else begin
      irq_pin_a_out <= pin_a_any ^ irq_pin_a_routing[`POLARITY_BIT];
      irq_pin_a_oe  <= (|irq_pin_a_routing[`ROUTE_MSB:0]) &
                       ~rate_and_sync_control[`OUTSIDE_CLK_BIT];
    end
  end

  // pin b drive; released when nothing is routed
  always @(posedge clk or negedge rst_sync_reg) begin
    if (!rst_sync_reg) begin
      irq_pin_b_out <= 1'b0;
      irq_pin_b_oe  <= 1'b0;
    end else begin
      irq_pin_b_out <= pin_b_any ^ irq_pin_b_routing[`POLARITY_BIT];
      irq_pin_b_oe  <= |irq_pin_b_routing[`ROUTE_MSB:0];
    end
  end

  // timing field copies
  always @(posedge clk or negedge rst_sync_reg) begin
    if (!rst_sync_reg) begin
      output_rate_sel        <= `SEL_RESET;
      doze_period_sel        <= `SEL_RESET;
      outside_clock_enable   <= 1'b0;
      outside_trigger_enable <= 1'b0;
    end else begin
      output_rate_sel        <= rate_and_sync_control[`RATE_MSB:`RATE_LSB];
      doze_period_sel        <= rate_and_sync_control[`DOZE_MSB:`DOZE_LSB];
      outside_clock_enable   <= rate_and_sync_control[`OUTSIDE_CLK_BIT];
      outside_trigger_enable <= rate_and_sync_control[`OUTSIDE_TRIG_BIT];
    end
  end

  // measurement field copies
  always @(posedge clk or negedge rst_sync_reg) begin
    if (!rst_sync_reg) begin
      overrange_disable <= 1'b0;
      low_noise_enable  <= 1'b0;
      bandwidth_sel     <= `SEL_RESET;
    end else begin
      overrange_disable <= measurement_settings[`RANGE_OFF_BIT];
      low_noise_enable  <= measurement_settings[`LOW_NOISE_BIT];
      bandwidth_sel     <= measurement_settings[`BW_MSB:`BW_LSB];
    end
  end

  // detector enables follow the processing phase
  always @(posedge clk or negedge rst_sync_reg) begin
    if (!rst_sync_reg) begin
      motion_detect_on <= 1'b0;
      still_detect_on  <= 1'b0;
    end else begin
      motion_detect_on <= motion_on_next;
      still_detect_on  <= still_on_next;
    end
  end

  // autosleep request, one cycle per stillness detection
  always @(posedge clk or negedge rst_sync_reg) begin
    if (!rst_sync_reg) begin
      doze_request <= 1'b0;
    end else begin
      doze_request <= seq_mode & doze_next;
    end
  end

  // pin a sampled as outside timebase when enabled
  always @(posedge clk or negedge rst_sync_reg) begin
    if (!rst_sync_reg) begin
      outside_clock_enable_d_reg      <= 1'b0;
      outside_clock_tick <= 1'b0;
    end else begin
      outside_clock_enable_d_reg      <= irq_pin_a_in;
      outside_clock_tick <= rate_and_sync_control[`OUTSIDE_CLK_BIT] &
                            irq_pin_a_in & ~outside_clock_enable_d_reg;
    end
  end

endmodule

// File: irq_cfg_map.vh
// register offsets, field positions and timing constants for the routing and measurement bank
`ifndef IRQ_CFG_MAP_VH
`define IRQ_CFG_MAP_VH
`define OFS_PIN_A_ROUTING   8'h3B
`define OFS_PIN_B_ROUTING   8'h3C
`define OFS_RATE_SYNC       8'h3D
`define OFS_MEASUREMENT     8'h3E
`define OFS_EVENT_STATUS    8'h40
`define OFS_MOTION_ENABLES  8'h41
`define OFS_CONTROL_STATE   8'h42
`define REG_RESET_VALUE     8'h00
`define POLARITY_BIT        7
`define ROUTE_MSB           6
`define RATE_MSB            7
`define RATE_LSB            5
`define DOZE_MSB            4
`define DOZE_LSB            2
`define OUTSIDE_CLK_BIT     1
`define OUTSIDE_TRIG_BIT    0
`define RANGE_OFF_BIT       7
`define AUTOSLEEP_BIT       6
`define PROC_MSB            5
`define PROC_LSB            4
`define LOW_NOISE_BIT       3
`define BW_MSB              2
`define BW_LSB              0
`define PROC_DEFAULT        2'h0
`define PROC_LINKED         2'h1
`define PROC_LOOPED         2'h2
`define EV_SAMPLE_READY     0
`define EV_QUEUE_NONEMPTY   1
`define EV_QUEUE_WATERMARK  2
`define EV_QUEUE_OVERFLOW   3
`define EV_STILL            4
`define EV_MOTION           5
`define EV_AWAKE            6
`define EV_MOTION_WARNING   7
`define EV_COUNT            8
`define REG_MSB             7
`define ENABLES_MSB         5
`define MOTION_EN_MSB       2
`define MOTION_EN_LSB       0
`define STILL_EN_MSB        5
`define STILL_EN_LSB        3
`define ENABLES_RESET       6'h00
`define STATUS_RESET        8'h00
`define SEL_RESET           3'h0
`define WM_COUNT_W          10
`define DOZE_PERIOD_MS_0    52
`define DOZE_PERIOD_MS_1    104
`define DOZE_PERIOD_MS_2    208
`define DOZE_PERIOD_MS_3    512
`define DOZE_PERIOD_MS_4    2048
`define DOZE_PERIOD_MS_5    4096
`define DOZE_PERIOD_MS_6    8192
`define DOZE_PERIOD_MS_7    24576
`endif

// File: irq_cfg_checker_asserts.sv
// concurrent checks on the routing and measurement bank ports
`timescale 1ns/1ps
module irq_cfg_checker (
  input wire logic       clk,
  input wire logic       resetn,
  input wire logic       avs_write,
  input wire logic       irq_pin_a_oe,
  input wire logic [2:0] output_rate_sel,
  input wire logic [2:0] doze_period_sel,
  input wire logic       outside_clock_enable,
  input wire logic       outside_trigger_enable,
  input wire logic       overrange_disable,
  input wire logic       low_noise_enable,
  input wire logic [2:0] bandwidth_sel,
  input wire logic       motion_detect_on,
  input wire logic       still_detect_on,
  input wire logic       doze_request,
  input wire logic       outside_clock_tick
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  property p_pin_a_input; outside_clock_enable |-> !irq_pin_a_oe; endproperty
  a_pin_a_input: assert property (p_pin_a_input) else $error("pin a driven with outside clock");
  property p_tick_cause; outside_clock_tick |-> outside_clock_enable || $past(outside_clock_enable); endproperty
  a_tick_cause: assert property (p_tick_cause) else $error("clock tick without outside clock");
  property p_rate_write; !$stable(output_rate_sel) |-> $past(avs_write) || $past(avs_write, 2); endproperty
  a_rate_write: assert property (p_rate_write) else $error("rate changed without write");
  property p_doze_write; !$stable(doze_period_sel) |-> $past(avs_write) || $past(avs_write, 2); endproperty
  a_doze_write: assert property (p_doze_write) else $error("doze period changed without write");
  property p_sync_write;
    !$stable({outside_clock_enable, outside_trigger_enable}) |-> $past(avs_write) || $past(avs_write, 2);
  endproperty
  a_sync_write: assert property (p_sync_write) else $error("sync bits changed without write");
  property p_meas_write;
    !$stable({overrange_disable, low_noise_enable, bandwidth_sel}) |-> $past(avs_write) || $past(avs_write, 2);
  endproperty
  a_meas_write: assert property (p_meas_write) else $error("measurement bits changed without write");
  property p_doze_pulse; doze_request |=> !doze_request; endproperty
  a_doze_pulse: assert property (p_doze_pulse) else $error("doze request longer than one cycle");
  property p_doze_seq; doze_request |-> !($past(motion_detect_on) && $past(still_detect_on)); endproperty
  a_doze_seq: assert property (p_doze_seq) else $error("doze request in default mode");
endmodule

bind irq_routing_and_measurement_settings_config irq_cfg_checker u_irq_cfg_checker (
  .clk, .resetn, .avs_write, .irq_pin_a_oe, .output_rate_sel, .doze_period_sel, .outside_clock_enable,
  .outside_trigger_enable, .overrange_disable, .low_noise_enable, .bandwidth_sel, .motion_detect_on,
  .still_detect_on, .doze_request, .outside_clock_tick);

// File: irq_host_pins.sv
// host side pin model: resolves both interrupt wires and sources the outside clock
`timescale 1ns/1ps
module irq_host_pins (
  input  wire logic clk,
  input  wire logic clk_en,
  input  wire logic a_out,
  input  wire logic a_oe,
  input  wire logic b_out,
  input  wire logic b_oe,
  output wire logic pin_a,
  output wire logic pin_b
);
  logic       fa = 1'b0;
  logic       fb = 1'b0;
  logic [1:0] div = 2'h0;
  // undriven wires wander so a stale level never passes
  always @(posedge clk) begin
    div <= div + 2'h1;
    fa  <= clk_en ? div[1] : ~pin_a;
    fb  <= ~pin_b;
  end
  assign pin_a = a_oe ? a_out : fa;
  assign pin_b = b_oe ? b_out : fb;
endmodule

// File: irq_routing_and_measurement_settings_config_test.sv
// self-checking bench for the routing and measurement bank
`timescale 1ns/1ps
`include "irq_cfg_map.vh"
module irq_routing_and_measurement_settings_config_test;
  logic        clk = 0, resetn = 0, rd = 0, wr = 0, clk_en = 0;
  logic [7:0]  adr = 0, ev = 0;
  logic [31:0] wdat = 0, q;
  logic [3:0]  be = 4'hF;
  logic [9:0]  lvl = 0, wm = 10'h3FF;
  wire  [31:0] rdat;
  wire  [2:0]  rate, doze, bw;
  wire         wreq, a_out, a_oe, b_out, b_oe, pin_a, pin_b, tick, m_on, s_on, oclk, otrig, orng, lnoise, dz;
  int          mismatches = 0, cmp_count = 0;
  always #4 clk = ~clk;
  irq_routing_and_measurement_settings_config u_irq_routing_and_measurement_settings_config (.clk(clk), .resetn(resetn),
    .avs_address(adr), .avs_read(rd), .avs_write(wr), .avs_writedata(wdat), .avs_byteenable(be),
    .avs_readdata(rdat), .avs_waitrequest(wreq), .ev_sample_ready(ev[0]), .ev_queue_nonempty(ev[1]),
    .ev_queue_overflow(ev[3]), .queue_level(lvl), .queue_watermark(wm), .still_detected(ev[4]),
    .motion_detected(ev[5]), .ev_motion_warning(ev[7]), .irq_pin_a_in(pin_a), .irq_pin_a_out(a_out),
    .irq_pin_a_oe(a_oe), .irq_pin_b_out(b_out), .irq_pin_b_oe(b_oe), .output_rate_sel(rate),
    .doze_period_sel(doze), .outside_clock_enable(oclk), .outside_trigger_enable(otrig),
    .overrange_disable(orng), .low_noise_enable(lnoise), .bandwidth_sel(bw), .motion_detect_on(m_on),
    .still_detect_on(s_on), .doze_request(dz), .outside_clock_tick(tick));
  irq_host_pins u_irq_host_pins (.clk(clk), .clk_en(clk_en), .a_out(a_out), .a_oe(a_oe), .b_out(b_out),
    .b_oe(b_oe), .pin_a(pin_a), .pin_b(pin_b));
  task automatic test_done;
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  // one bus transfer, held until waitrequest is sampled low
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
    int n;
    n = 0;
    rd <= !w;
    wr <= w;
    adr <= a;
    wdat <= {24'h0, d};
    do begin
      @(posedge clk);
      n++;
    end while (wreq !== 1'b0 && n < 50);
    q = rdat;
    if (n >= 50) begin
      mismatches++;
      test_done;
    end
    rd <= 1'b0;
    wr <= 1'b0;
    @(posedge clk);
  endtask
  task automatic t_reset;
    for (int a = 8'h3B; a <= 8'h3E; a++) begin
      bus(0, a[7:0], 8'h00);
      check(q, 32'h0);
    end
    check({a_oe, b_oe}, 2'b00);
  endtask
  task automatic t_fields;
    for (int i = 0; i < 5; i++) begin
      bus(1, `OFS_RATE_SYNC, {i[2:0], i[2:0], 2'b01});
      repeat (2) @(posedge clk);
      check({rate, doze, otrig}, {i[2:0], i[2:0], 1'b1});
      bus(1, `OFS_RATE_SYNC, {i[2:0], 3'h7 - i[2:0], 2'b00});
      bus(0, `OFS_RATE_SYNC, 8'h00);
      check(q, {24'h0, i[2:0], 3'h7 - i[2:0], 2'b00});
      bus(1, `OFS_MEASUREMENT, {i[0], 1'b0, 2'b00, !i[0], i[2:0]});
      repeat (2) @(posedge clk);
      check({orng, lnoise, bw, doze}, {i[0], !i[0], i[2:0], 3'h7 - i[2:0]});
    end
    be <= 4'h0;
    bus(1, `OFS_MEASUREMENT, 8'hFF);
    be <= 4'hF;
    bus(0, `OFS_MEASUREMENT, 8'h00);
    check(q, 32'h0000_000C);
    bus(0, 8'h50, 8'h00);
    check(q, 32'h0);
  endtask
  // route, flip polarity, combine and acknowledge
  task automatic t_pins;
    bus(1, `OFS_PIN_A_ROUTING, 8'h01);
    ev <= 8'h01;
    repeat (3) @(posedge clk);
    check({a_oe, pin_a}, 2'b11);
    bus(1, `OFS_PIN_A_ROUTING, 8'h81);
    ev <= 8'h00;
    repeat (3) @(posedge clk);
    check(pin_a, 1'b0);
    bus(0, `OFS_EVENT_STATUS, 8'h00);
    check(q[0], 1'b1);
    repeat (3) @(posedge clk);
    check(pin_a, 1'b1);
    bus(1, `OFS_PIN_A_ROUTING, 8'h0A);
    ev <= 8'h08;
    repeat (3) @(posedge clk);
    check(pin_a, 1'b1);
    bus(1, `OFS_PIN_A_ROUTING, 8'h00);
    ev <= 8'h02;
    repeat (3) @(posedge clk);
    check(a_oe, 1'b0);
    bus(0, `OFS_EVENT_STATUS, 8'h00);
    check(q[3:1], 3'b101);
    bus(1, `OFS_PIN_B_ROUTING, 8'h20);
    ev <= 8'h20;
    repeat (3) @(posedge clk);
    check({b_oe, pin_b}, 2'b10);
    ev <= 8'h80;
    repeat (3) @(posedge clk);
    check(pin_b, 1'b1);
    ev <= 8'h00;
  endtask
  task automatic t_level;
    lvl <= 10'd5;
    wm <= 10'd5;
    repeat (2) @(posedge clk);
    bus(0, `OFS_EVENT_STATUS, 8'h00);
    check(q[2], 1'b1);
    lvl <= 10'd4;
    repeat (2) @(posedge clk);
    bus(0, `OFS_EVENT_STATUS, 8'h00);
    bus(0, `OFS_EVENT_STATUS, 8'h00);
    check(q[2], 1'b0);
  endtask
  task automatic t_modes;
    int n;
    bus(1, `OFS_MEASUREMENT, 8'h10);
    bus(1, `OFS_MOTION_ENABLES, 8'h00);
    repeat (2) @(posedge clk);
    check({m_on, s_on}, 2'b11);
    bus(1, `OFS_MOTION_ENABLES, 8'h3F);
    repeat (2) @(posedge clk);
    check({m_on, s_on}, 2'b10);
    bus(1, `OFS_MEASUREMENT, 8'h60);
    repeat (2) @(posedge clk);
    check({m_on, s_on}, 2'b10);
    ev <= 8'h20;
    repeat (4) @(posedge clk);
    check({m_on, s_on}, 2'b01);
    ev <= 8'h10;
    n = 0;
    repeat (4) begin
      @(posedge clk);
      n += dz;
    end
    check(n, 1);
    ev <= 8'h00;
    bus(0, `OFS_EVENT_STATUS, 8'h00);
    check(q[5:4], 2'b00);
  endtask
  task automatic t_outside;
    int n;
    n = 0;
    bus(1, `OFS_PIN_A_ROUTING, 8'h01);
    bus(1, `OFS_RATE_SYNC, 8'h02);
    clk_en <= 1'b1;
    repeat (32) begin
      @(posedge clk);
      n += tick;
    end
    check({oclk, a_oe, n > 0}, 3'b101);
  endtask
  initial begin
    repeat (6) @(posedge clk);
    resetn <= 1'b1;
    repeat (3) @(posedge clk);
    t_reset;
    t_fields;
    t_pins;
    t_level;
    t_modes;
    t_outside;
    test_done;
  end
  initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    test_done;
  end
endmodule
